// *** hdl/mmd_pkg.sv ***
// Purpose: Constants and carriers for the memory map and vector decoder
// Assumes: 16-bit CPU address space, 8-bit data
// Notes:   APB offsets of the CPU-side window are byte addresses
package mmd_pkg;
   localparam logic [15:0] RAM1_LO      = 16'h0040;
   localparam logic [15:0] RAM1_HI      = 16'h043F;
   localparam logic [15:0] RAM2_LO      = 16'h0580;
   localparam logic [15:0] RAM2_HI      = 16'h097F;
   localparam logic [15:0] PAGE0_END    = 16'h00FF;
   localparam logic [15:0] FLASH_LO     = 16'h8000;
   localparam logic [15:0] FLASH_HI     = 16'hFDFF;
   localparam logic [15:0] PROT1_ADDR   = 16'hFF80;
   localparam logic [15:0] PROT2_ADDR   = 16'hFF81;
   localparam logic [15:0] CTRL_ADDR    = 16'hFF88;
   localparam logic [15:0] VEC_LO       = 16'hFFCC;
   localparam logic [15:0] VEC_HI       = 16'hFFFF;
   localparam logic [15:0] SP_RESET     = 16'h00FF;
   localparam logic [4:0]  SRC_LOWEST   = 5'h18;
   localparam logic [2:0]  IRQ_PUSH_N   = 3'h5;
   localparam logic [2:0]  CALL_PUSH_N  = 3'h2;
   localparam int          ROW_BYTES    = 64;
   localparam int          PAGE_BYTES   = 128;
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
   localparam logic [7:0]  PROT_RESET   = 8'hFF;
   // Control register fields
   localparam int          CTL_PGM      = 0;
   localparam int          CTL_ERASE    = 1;
   localparam int          CTL_MASS     = 2;
   localparam int          CTL_HIGH_VOLTAGE_ENABLE     = 3;
   localparam logic [7:0]  CTL_MASK     = 8'h0F;
   // APB map (byte addresses)
   localparam logic [11:0] A_DECODE     = 12'h000;
   localparam logic [11:0] A_RESULT     = 12'h004;
   localparam logic [11:0] A_STACK      = 12'h008;
   localparam logic [11:0] A_SP         = 12'h00C;
   localparam logic [11:0] A_PROT1      = 12'h010;
   localparam logic [11:0] A_PROT2      = 12'h014;
   localparam logic [11:0] A_CTRL       = 12'h018;
   localparam logic [11:0] A_SECURE     = 12'h01C;

   typedef enum logic [2:0] {
      RG_NONE = 3'h0, RG_RAM = 3'h1, RG_FLASH = 3'h2, RG_FREG = 3'h3, RG_VEC = 3'h4
   } mmd_region_e;

   typedef enum logic [1:0] {
      ST_NONE = 2'h0, ST_PUSH = 2'h1, ST_PULL = 2'h2, ST_IRQ = 2'h3
   } mmd_stack_e;

   typedef struct packed {
      mmd_region_e region;
      logic        page0;
      logic        vec_hi;
      logic [4:0]  vec_src;
      logic        vec_valid;
   } mmd_dec_s;
endpackage : mmd_pkg

// *** hdl/mmd_top.sv ***
// Purpose: Memory map, vector and stack pointer decode with flash registers
// Assumes: APB slave, 32-bit data, one clock, async active-high reset
// Notes:   Decoded address is written over APB, result read back
`timescale 1ns/1ps
module mmd_top (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Stack pointer and flash status
   output logic      [15:0] sp_o,
   output logic      [3:0]  flash_ctrl_o,
   output logic      [6:0]  row_index_o,
   output logic      [7:0]  page_index_o
);

   typedef struct packed {
      logic [15:0]       addr;
      mmd_pkg::mmd_dec_s dec;
      logic [15:0]       sp;
      logic [7:0]        prot1;
      logic [7:0]        prot2;
      logic [3:0]        ctrl;
      logic              secure;
      logic [31:0]       rdata;
      logic              ready;
      logic              err;
   } mmd_state_s;

   mmd_state_s st;
   mmd_state_s next_st;

   function automatic mmd_pkg::mmd_dec_s decode(input logic [15:0] a);
      mmd_pkg::mmd_dec_s d;
      logic [15:0]       off;
      d   = '0;
      off = a - mmd_pkg::VEC_LO;
      d.region = mmd_pkg::RG_NONE;
      // Ranges are disjoint, so priority order here never matters
      if ((a >= mmd_pkg::RAM1_LO && a <= mmd_pkg::RAM1_HI) ||
          (a >= mmd_pkg::RAM2_LO && a <= mmd_pkg::RAM2_HI)) begin
         d.region = mmd_pkg::RG_RAM;
      end else if (a >= mmd_pkg::FLASH_LO && a <= mmd_pkg::FLASH_HI) begin
         d.region = mmd_pkg::RG_FLASH;
      end else if (a == mmd_pkg::PROT1_ADDR || a == mmd_pkg::PROT2_ADDR ||
                   a == mmd_pkg::CTRL_ADDR) begin
         d.region = mmd_pkg::RG_FREG;
      end else if (a >= mmd_pkg::VEC_LO) begin
         d.region = mmd_pkg::RG_VEC;
      end
      d.page0 = (d.region == mmd_pkg::RG_RAM) && (a <= mmd_pkg::PAGE0_END);
      if (d.region == mmd_pkg::RG_VEC) begin
         d.vec_hi = ~a[0];
         // Source 24 sits lowest; sources above IF1 have number zero
         if (off[6:1] < 6'(mmd_pkg::SRC_LOWEST)) begin
            d.vec_src   = mmd_pkg::SRC_LOWEST - off[5:1];
            d.vec_valid = 1'b1;
         end
      end
      return d;
   endfunction : decode

   logic        setup;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic [3:0]  ctrl_w;
   logic [15:0] stack_step;

   always_comb begin
      next_st    = st;
      setup      = psel_i && !penable_i;
      wr         = psel_i && penable_i && pwrite_i;
      // Read data is taken at setup so it stands together with pready
      rd         = psel_i && !penable_i && !pwrite_i;
      ctrl_w     = pwdata_i[3:0];
      stack_step = 16'h0000;
      mapped     = (paddr_i[11:5] == 7'h00) && (paddr_i[1:0] == 2'b00);
      next_st.ready = setup;
      next_st.err   = setup && !mapped;
      next_st.dec   = decode(st.addr);
      if (wr && mapped) begin
         unique case (paddr_i)
            mmd_pkg::A_DECODE: next_st.addr = pwdata_i[15:0];
            mmd_pkg::A_STACK: begin
               unique case (mmd_pkg::mmd_stack_e'(pwdata_i[1:0]))
                  mmd_pkg::ST_NONE: stack_step = 16'h0000;
                  mmd_pkg::ST_PUSH: stack_step = 16'(pwdata_i[2] ?
                                     mmd_pkg::CALL_PUSH_N : 3'h1);
                  mmd_pkg::ST_IRQ:  stack_step = 16'(mmd_pkg::IRQ_PUSH_N);
                  mmd_pkg::ST_PULL: stack_step = 16'h0000;
               endcase
               if (pwdata_i[1:0] == 2'(mmd_pkg::ST_PULL)) begin
                  next_st.sp = st.sp + 16'h0001;
               end else begin
                  next_st.sp = st.sp - stack_step;
               end
            end
            mmd_pkg::A_SP:     next_st.sp = pwdata_i[15:0];
            mmd_pkg::A_PROT1:  next_st.prot1 = pwdata_i[7:0];
            mmd_pkg::A_PROT2:  next_st.prot2 = pwdata_i[7:0];
            mmd_pkg::A_CTRL: begin
               // Both selects asked at once: request refused, both keep old value
               if (ctrl_w[mmd_pkg::CTL_PGM] && ctrl_w[mmd_pkg::CTL_ERASE]) begin
                  ctrl_w[mmd_pkg::CTL_PGM]   = st.ctrl[mmd_pkg::CTL_PGM];
                  ctrl_w[mmd_pkg::CTL_ERASE] = st.ctrl[mmd_pkg::CTL_ERASE];
               end
               // High voltage needs a select active
               if (!(ctrl_w[mmd_pkg::CTL_PGM] || ctrl_w[mmd_pkg::CTL_ERASE])) begin
                  ctrl_w[mmd_pkg::CTL_HIGH_VOLTAGE_ENABLE] = 1'b0;
               end
               next_st.ctrl = ctrl_w;
            end
            // Security only ever sets until reset
            mmd_pkg::A_SECURE: next_st.secure = st.secure | pwdata_i[0];
            default: ;
         endcase
      end
      next_st.rdata = 32'h0000_0000;
      if (rd && mapped) begin
         unique case (paddr_i)
            mmd_pkg::A_DECODE: next_st.rdata = {16'h0000, st.addr};
            mmd_pkg::A_RESULT: next_st.rdata = {19'h0_0000, st.dec.vec_valid,
                                   st.dec.vec_src, st.dec.vec_hi, st.dec.page0,
                                   2'b00, st.dec.region};
            mmd_pkg::A_SP:     next_st.rdata = {16'h0000, st.sp};
            // Secure hides protect bytes as erased
            mmd_pkg::A_PROT1:  next_st.rdata = {24'h00_0000,
                                   st.secure ? mmd_pkg::ERASED_BYTE : st.prot1};
            mmd_pkg::A_PROT2:  next_st.rdata = {24'h00_0000,
                                   st.secure ? mmd_pkg::ERASED_BYTE : st.prot2};
            mmd_pkg::A_CTRL:   next_st.rdata = {28'h000_0000, st.ctrl};
            mmd_pkg::A_SECURE: next_st.rdata = {31'h0000_0000, st.secure};
            default:           next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         st        <= '0;
         st.sp     <= mmd_pkg::SP_RESET;
         st.prot1  <= mmd_pkg::PROT_RESET;
         st.prot2  <= mmd_pkg::PROT_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o     = st.rdata;
   assign pready_o     = st.ready;
   assign pslverr_o    = st.err;
   assign sp_o         = st.sp;
   assign flash_ctrl_o = st.ctrl;
   // Row is address bit 6 upward, page bit 7 upward
   assign row_index_o  = st.addr[12:$clog2(mmd_pkg::ROW_BYTES)];
   assign page_index_o = st.addr[14:$clog2(mmd_pkg::PAGE_BYTES)];

   a_sel_interlock: assert property (@(posedge clock_i) disable iff (reset_i)
      !(st.ctrl[mmd_pkg::CTL_PGM] && st.ctrl[mmd_pkg::CTL_ERASE]))
      else $error("program and erase both set");
   a_high_voltage_enable_needs_sel: assert property (@(posedge clock_i) disable iff (reset_i)
      st.ctrl[mmd_pkg::CTL_HIGH_VOLTAGE_ENABLE] |-> (st.ctrl[mmd_pkg::CTL_PGM] | st.ctrl[mmd_pkg::CTL_ERASE]))
      else $error("high voltage without select");
   a_ram_decode: assert property (@(posedge clock_i) disable iff (reset_i)
      $changed(st.addr) |=> (st.dec.region == mmd_pkg::RG_RAM) ==
         (($past(st.addr) >= 16'h0040 && $past(st.addr) <= 16'h043F) ||
          ($past(st.addr) >= 16'h0580 && $past(st.addr) <= 16'h097F)))
      else $error("ram decode wrong");
   a_flash_decode: assert property (@(posedge clock_i) disable iff (reset_i)
      ##1 (st.dec.region == mmd_pkg::RG_FLASH) ==
         ($past(st.addr) >= 16'h8000 && $past(st.addr) <= 16'hFDFF))
      else $error("flash decode wrong");
   a_vec_pair: assert property (@(posedge clock_i) disable iff (reset_i)
      ##1 ($past(st.addr) == 16'hFFCC) |-> st.dec.vec_hi && st.dec.vec_src == 5'h18)
      else $error("lowest vector wrong");
   a_sp_pull: assert property (@(posedge clock_i) disable iff (reset_i)
      (wr && paddr_i == mmd_pkg::A_STACK && pwdata_i[1:0] == 2'h2) |=>
         st.sp == $past(st.sp) + 16'h0001)
      else $error("pull did not increment");
   a_sp_irq: assert property (@(posedge clock_i) disable iff (reset_i)
      (wr && paddr_i == mmd_pkg::A_STACK && pwdata_i[1:0] == 2'h3) |=>
         st.sp == $past(st.sp) - 16'h0005)
      else $error("irq push not five");
   a_secure_hold: assert property (@(posedge clock_i) disable iff (reset_i)
      st.secure |=> st.secure)
      else $error("security dropped");
   a_page0_ram: assert property (@(posedge clock_i) disable iff (reset_i)
      st.dec.page0 |-> st.dec.region == mmd_pkg::RG_RAM)
      else $error("page zero outside ram");
   a_apb_ready: assert property (@(posedge clock_i) disable iff (reset_i)
      (psel_i && !penable_i) |=> pready_o)
      else $error("ready not one cycle after setup");
   a_rdata_idle: assert property (@(posedge clock_i) disable iff (reset_i)
      !pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data outside access cycle");
   a_err_ready: assert property (@(posedge clock_i) disable iff (reset_i)
      pslverr_o |-> pready_o)
      else $error("error without ready");
   a_vec_area: assert property (@(posedge clock_i) disable iff (reset_i)
      $changed(st.addr) |=> (st.dec.region == mmd_pkg::RG_VEC) ==
         ($past(st.addr) >= mmd_pkg::VEC_LO))
      else $error("vector area decode wrong");
   a_freg_decode: assert property (@(posedge clock_i) disable iff (reset_i)
      $changed(st.addr) |=> (st.dec.region == mmd_pkg::RG_FREG) ==
         ($past(st.addr) == mmd_pkg::PROT1_ADDR || $past(st.addr) == mmd_pkg::PROT2_ADDR ||
          $past(st.addr) == mmd_pkg::CTRL_ADDR))
      else $error("flash register decode wrong");
   a_vec_even_high: assert property (@(posedge clock_i) disable iff (reset_i)
      (st.dec.region == mmd_pkg::RG_VEC && $stable(st.addr)) |->
         st.dec.vec_hi == !st.addr[0])
      else $error("vector byte order wrong");
   a_vec_src_range: assert property (@(posedge clock_i) disable iff (reset_i)
      st.dec.vec_valid |-> (st.dec.region == mmd_pkg::RG_VEC &&
         st.dec.vec_src >= 5'h01 && st.dec.vec_src <= mmd_pkg::SRC_LOWEST))
      else $error("vector source out of range");
   a_one_region: assert property (@(posedge clock_i) disable iff (reset_i)
      st.dec.region <= mmd_pkg::RG_VEC)
      else $error("illegal region code");
   a_page0_range: assert property (@(posedge clock_i) disable iff (reset_i)
      (st.dec.region == mmd_pkg::RG_RAM && $stable(st.addr) &&
         st.addr <= mmd_pkg::PAGE0_END) |-> st.dec.page0)
      else $error("page zero ram not flagged");
   a_sp_reset: assert property (@(posedge clock_i) disable iff (reset_i)
      $fell(reset_i) |-> st.sp == mmd_pkg::SP_RESET)
      else $error("stack pointer reset value wrong");
   a_sp_call: assert property (@(posedge clock_i) disable iff (reset_i)
      (wr && paddr_i == mmd_pkg::A_STACK && pwdata_i[2:0] == 3'h5) |=>
         st.sp == $past(st.sp) - 16'h0002)
      else $error("call push not two");
   a_sp_push: assert property (@(posedge clock_i) disable iff (reset_i)
      (wr && paddr_i == mmd_pkg::A_STACK && pwdata_i[2:0] == 3'h1) |=>
         st.sp == $past(st.sp) - 16'h0001)
      else $error("push did not decrement");
   a_prot_write: assert property (@(posedge clock_i) disable iff (reset_i)
      (wr && paddr_i == mmd_pkg::A_PROT1) |=> st.prot1 == $past(pwdata_i[7:0]))
      else $error("protect byte write lost");
   a_secure_read: assert property (@(posedge clock_i) disable iff (reset_i)
      (rd && paddr_i == mmd_pkg::A_PROT1 && st.secure) |=>
         prdata_o == {24'h00_0000, mmd_pkg::ERASED_BYTE})
      else $error("protect byte visible while secure");

endmodule : mmd_top

// *** tb/memory_map_vector_decode_test.sv ***
// Purpose: Self-checking bench for the memory map and vector decoder
// Assumes: Bus answers through the CPU model
// Notes:   Secure mode is set last, it cannot be cleared
`timescale 1ns/1ps
module memory_map_vector_decode_test;
   logic        clock_i, reset_i, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, m;
   logic [15:0] sp, a;
   logic [3:0]  fctl;
   logic [6:0]  row;
   logic [7:0]  page;
   int          n_mismatch = 0, total_checks = 0, cycles = 0;
   logic [15:0] alist [16] = '{16'h0040, 16'h00FF, 16'h0100, 16'h043F, 16'h0440, 16'h0580,
      16'h097F, 16'h0980, 16'h8000, 16'h8040, 16'hFDFF, 16'hFF80, 16'hFF88, 16'hFFCC,
      16'hFFFB, 16'hFFFE};
   logic [7:0]  cw [7] = '{8'h01, 8'h03, 8'h02, 8'h0A, 8'h00, 8'h08, 8'h04};
   logic [7:0]  ce [7] = '{8'h01, 8'h01, 8'h02, 8'h0A, 8'h00, 8'h00, 8'h04};
   logic [2:0]  so [5] = '{3'h1, 3'h5, 3'h3, 3'h2, 3'h0};
   logic [15:0] se [5] = '{16'h01FF, 16'h01FD, 16'h01F8, 16'h01F9, 16'h01F9};

   mmd_top i_dut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sp_o(sp), .flash_ctrl_o(fctl),
      .row_index_o(row), .page_index_o(page));
   mmd_cpu_model i_cpu (.clock_i(clock_i), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
      .pready_i(pready), .pslverr_i(pslverr));

   task automatic close_out();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      i_cpu.xfer(1'b1, ad, d, q, err);
   endtask : wr
   task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
      i_cpu.xfer(1'b0, ad, 32'h0000_0000, q, err);
      chk(q, exp);
   endtask : rd
   // Expected decode: {valid, source, high byte, page zero, 2'b0, region}
   function automatic logic [31:0] dec(input logic [15:0] x);
      logic [2:0] rg;
      logic [4:0] src;
      rg  = 3'h0;
      src = 5'(24 - ((x - 16'hFFCC) >> 1));
      if ((x >= 16'h0040 && x <= 16'h043F) || (x >= 16'h0580 && x <= 16'h097F)) rg = 3'h1;
      else if (x >= 16'h8000 && x <= 16'hFDFF) rg = 3'h2;
      else if (x == 16'hFF80 || x == 16'hFF81 || x == 16'hFF88) rg = 3'h3;
      else if (x >= 16'hFFCC) rg = 3'h4;
      return {19'h0, x >= 16'hFFCC && x <= 16'hFFFB, src, ~x[0], rg == 3'h1 && x <= 16'h00FF,
              2'b00, rg};
   endfunction : dec

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   // Run should finish in a few hundred cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles > 20000) begin
         n_mismatch++;
         close_out();
      end
   end

   initial begin
      reset_i = 1'b1;
      repeat (10) @(posedge clock_i);
      reset_i <= 1'b0;
      rd(12'h00C, 32'h0000_00FF);
      chk({16'h0, sp}, 32'h0000_00FF);
      rd(12'h018, 32'h0000_0000);
      foreach (alist[i]) begin
         a = alist[i];
         wr(12'h000, {16'h0, a});
         i_cpu.xfer(1'b0, 12'h004, 32'h0000_0000, q, err);
         // Vector fields only mean something inside the vector area
         m = (a < 16'hFFCC) ? 32'h0000_0027 : (a <= 16'hFFFB) ? 32'h0000_1FE7 : 32'h0000_1067;
         chk(q & m, dec(a) & m);
         chk({17'h0, row, page}, {17'h0, a[12:6], a[14:7]});
      end
      wr(12'h00C, 32'h0000_0200);
      rd(12'h00C, 32'h0000_0200);
      foreach (so[i]) begin
         wr(12'h008, {29'h0, so[i]});
         rd(12'h00C, {16'h0, se[i]});
         chk({16'h0, sp}, {16'h0, se[i]});
      end
      foreach (cw[i]) begin
         wr(12'h018, {24'h0, cw[i]});
         rd(12'h018, {24'h0, ce[i]});
         chk({28'h0, fctl}, {28'h0, ce[i][3:0]});
      end
      wr(12'h010, 32'h0000_005A);
      wr(12'h014, 32'h0000_00A5);
      rd(12'h010, 32'h0000_005A);
      rd(12'h014, 32'h0000_00A5);
      chk({31'h0, err}, 32'h0000_0000);
      i_cpu.xfer(1'b0, 12'h020, 32'h0000_0000, q, err);
      chk({31'h0, err}, 32'h0000_0001);
      i_cpu.xfer(1'b1, 12'h012, 32'h0000_0011, q, err);
      chk({31'h0, err}, 32'h0000_0001);
      rd(12'h014, 32'h0000_00A5);
      wr(12'h01C, 32'h0000_0001);
      rd(12'h010, 32'h0000_00FF);
      close_out();
   end
endmodule : memory_map_vector_decode_test

// *** tb/mmd_cpu_model.sv ***
// Purpose: CPU-side bus master issuing decode, stack and flash accesses
// Assumes: Slave answers with pready; the bench timeout ends any hang
// Notes:   Idle bus shows inverted address and data, never the last value
`timescale 1ns/1ps
module mmd_cpu_model (
   // Clock
   input  wire logic        clock_i,
   // Bus master side
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic      [11:0] paddr_o,
   output logic      [31:0] pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   initial begin
      psel_o    = 1'b0;
      penable_o = 1'b0;
      pwrite_o  = 1'b0;
      paddr_o   = 12'h000;
      pwdata_o  = 32'h0000_0000;
   end

   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge clock_i);
      psel_o   <= 1'b1;
      pwrite_o <= wr;
      paddr_o  <= a;
      pwdata_o <= d;
      @(posedge clock_i);
      penable_o <= 1'b1;
      // Request held until the edge that samples pready high
      do @(posedge clock_i); while (pready_i !== 1'b1);
      q   = prdata_i;
      err = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      paddr_o   <= ~a;
      pwdata_o  <= ~d;
   endtask : xfer
endmodule : mmd_cpu_model
